/* reset_seq_pkg.sv */
package reset_seq_pkg;

  // core clock rate
  localparam int CLK_MHZ = 200;

  // start-up timer lengths
  localparam int POWERUP_TIMER_W          = 11;
  localparam int POWERUP_TIMER_TICKS      = 2048;
  localparam int OST_CYCLES      = 1024;
  localparam int PLL_LOCK_MS     = 2;
  localparam int PLL_LOCK_CYCLES = PLL_LOCK_MS * 1000 * 1000 * CLK_MHZ / 1000;

  // least times, rounded up to whole core cycles
  localparam int EXT_FILTER_NS     = 50;
  localparam int EXT_FILTER_CYCLES = (EXT_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int BOR_MIN_NS        = 200;
  localparam int BOR_MIN_CYCLES    = (BOR_MIN_NS * CLK_MHZ + 999) / 1000;

  localparam int FILT_W = 8;
  localparam int CNT_W  = 20;

  // brown-out mode field encodings
  localparam logic [1:0] BOR_MODE_OFF   = 2'h0;
  localparam logic [1:0] BOR_MODE_SW    = 2'h1;
  localparam logic [1:0] BOR_MODE_NOSLP = 2'h2;
  localparam logic [1:0] BOR_MODE_ON    = 2'h3;

  // reset values of status bits
  localparam logic SW_BOR_EN_POR = 1'b1;
  localparam logic FLAG_CLEARED  = 1'b0;
  localparam logic FLAG_SET      = 1'b1;

  typedef enum logic [2:0] {
    OSC_RC     = 3'h0,
    OSC_EC     = 3'h1,
    OSC_INTIO  = 3'h2,
    OSC_LP     = 3'h3,
    OSC_XT     = 3'h4,
    OSC_HS     = 3'h5,
    OSC_HIGH_SPEED_PLL_MODE  = 3'h6
  } osc_mode_t;

  typedef enum logic [2:0] {
    ST_HOLD = 3'h0,
    ST_POWERUP_TIMER = 3'h1,
    ST_OST  = 3'h2,
    ST_PLL  = 3'h3,
    ST_RUN  = 3'h4
  } seq_state_t;

  // configuration bits, static while running
  typedef struct packed {
    logic       ext_reset_pin_enable;
    logic [1:0] brownout_mode_sel;
    logic [1:0] brownout_level_sel;
    logic       powerup_timer_off;
    osc_mode_t  osc_mode;
  } cfg_t;

  // reset control register bits seen by software
  typedef struct packed {
    logic sw_brownout_enable;
    logic por_flag_n;
    logic brownout_flag_n;
  } status_t;

endpackage : reset_seq_pkg

/* reset_sequencer.sv */
`timescale 1ns/100ps
// Function
// - reset held while enabled pin low
// - reset pin never driven by device
// - disabled pin becomes plain digital input
// - power-on flag cleared by POR only
// - enabled brown-out resets after minimum duration
// - brown-out reset holds while supply low
// - brown-out during power-up timer restarts it
// - brown-out and power-up timer independent
// - software enable gates mode 01 only
// - threshold only from configuration field
// - brown-out flag cleared on BOR/POR
// - mode 10 disables detection in sleep
// - modes 00/11 fixed, software cannot change
// - power-up timer counts 2048 RC ticks
// - power-up timer active when off-bit clear
// - oscillator start-up adds 1024 oscillator cycles
// - start-up count only crystal modes, POR/BOR/wake
// - PLL mode adds 2 ms lock time
// - timer starts after POR pulse clears
// - RC without timer releases immediately
module reset_sequencer #(
  parameter int PLL_LOCK_CYCLES = reset_seq_pkg::PLL_LOCK_CYCLES
) (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_clk_en,
  input  wire reset_seq_pkg::cfg_t  i_cfg,
  input  wire logic                 i_ext_reset_pin_n,
  input  wire logic                 i_por_pulse,
  input  wire logic                 i_brownout_below,
  input  wire logic                 i_internal_rc_clock,
  input  wire logic                 i_osc_input_pin,
  input  wire logic                 i_sleep,
  input  wire logic                 i_pm_exit,
  input  wire logic                 i_sw_brownout_wr,
  input  wire logic                 i_sw_brownout_wdata,
  input  wire logic                 i_por_flag_wr_one,
  input  wire logic                 i_brownout_flag_wr_one,
  output logic                      o_core_reset,
  output logic                      o_startup_busy,
  output logic                      o_ext_reset_pin_out,
  output logic                      o_ext_reset_pin_oe,
  output logic                      o_ext_pin_data,
  output logic [1:0]                o_brownout_level_sel,
  output logic                      o_brownout_detect_en,
  output reset_seq_pkg::status_t    o_status,
  output reset_seq_pkg::seq_state_t o_seq_state
);
  import reset_seq_pkg::*;
  // refuse timer lengths the shared counter cannot hold
  if (PLL_LOCK_CYCLES < 1 || PLL_LOCK_CYCLES >= (1 << CNT_W) ||
      POWERUP_TIMER_TICKS != (1 << POWERUP_TIMER_W) || POWERUP_TIMER_W >= CNT_W) begin : g_bad_param
    $error("start-up timer length out of range for counter width");
  end
  localparam logic [CNT_W-1:0]  POWERUP_TIMER_LAST = CNT_W'(POWERUP_TIMER_TICKS - 1);
  localparam logic [CNT_W-1:0]  OST_LAST  = CNT_W'(OST_CYCLES - 1);
  localparam logic [CNT_W-1:0]  PLL_LAST  = CNT_W'(PLL_LOCK_CYCLES - 1);
  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(EXT_FILTER_CYCLES - 1);
  localparam logic [FILT_W-1:0] BOR_LAST  = FILT_W'(BOR_MIN_CYCLES - 1);
  function automatic logic needs_ost(input osc_mode_t mode);
    needs_ost = (mode == OSC_LP) || (mode == OSC_XT) || (mode == OSC_HS) ||
                (mode == OSC_HIGH_SPEED_PLL_MODE);
  endfunction : needs_ost
  // two-stage synchronisers for asynchronous inputs
  // reset to pin released, por asserted: no start before the pulse is seen
  localparam int               NSYNC     = 5;
  localparam logic [NSYNC-1:0] SYNC_IDLE = 5'h18;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign async_in = {i_ext_reset_pin_n, i_por_pulse, i_brownout_below,
                     i_internal_rc_clock, i_osc_input_pin};
  for (genvar g = 0; g < NSYNC; g++) begin : g_sync
    always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
        sync1_reg[g] <= SYNC_IDLE[g];
        sync2_reg[g] <= SYNC_IDLE[g];
      end else if (i_clk_en) begin
        sync1_reg[g] <= async_in[g];
        sync2_reg[g] <= sync1_reg[g];
      end
    end
  end
  logic pin_s, por_s, bor_low_s, rc_s, osc_s;
  assign {pin_s, por_s, bor_low_s, rc_s, osc_s} = sync2_reg;
  // edge detect of the slow clocks, after synchronisation
  logic rc_d_reg;
  logic osc_d_reg;
  logic rc_tick;
  logic osc_tick;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rc_d_reg  <= 1'b0;
      osc_d_reg <= 1'b0;
    end else if (i_clk_en) begin
      rc_d_reg  <= rc_s;
      osc_d_reg <= osc_s;
    end
  end
  assign rc_tick  = rc_s & ~rc_d_reg;
  assign osc_tick = osc_s & ~osc_d_reg;
  // pin level only accepted after it stays put for the filter time
  // glitch filter
  logic              pin_filt_reg;
  logic [FILT_W-1:0] filt_cnt_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pin_filt_reg <= 1'b1;
      filt_cnt_reg <= '0;
    end else if (i_clk_en) begin
      if (pin_s == pin_filt_reg) begin
        filt_cnt_reg <= '0;
      end else if (filt_cnt_reg == FILT_LAST) begin
        pin_filt_reg <= pin_s;
        filt_cnt_reg <= '0;
      end else begin
        filt_cnt_reg <= filt_cnt_reg + 1'b1;
      end
    end
  end
  logic ext_active;
  assign ext_active = i_cfg.ext_reset_pin_enable & ~pin_filt_reg;
  // software brown-out enable, meaningful only in mode 01
  logic sw_bor_en_reg;
  logic mode_sw;
  assign mode_sw = (i_cfg.brownout_mode_sel == BOR_MODE_SW);
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sw_bor_en_reg <= SW_BOR_EN_POR;
    end else if (i_clk_en) begin
      if (por_s) begin
        sw_bor_en_reg <= SW_BOR_EN_POR;
      end else if (i_sw_brownout_wr && mode_sw) begin
        sw_bor_en_reg <= i_sw_brownout_wdata;
      end
    end
  end
  logic bor_en;
  always_comb begin
    case (i_cfg.brownout_mode_sel)
      BOR_MODE_OFF:   bor_en = 1'b0;
      BOR_MODE_SW:    bor_en = sw_bor_en_reg;
      BOR_MODE_NOSLP: bor_en = ~i_sleep;
      BOR_MODE_ON:    bor_en = 1'b1;
      default:        bor_en = 1'b0;
    endcase
  end
  // held until supply back above threshold
  logic              bor_active_reg;
  logic [FILT_W-1:0] bor_cnt_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      bor_active_reg <= 1'b0;
      bor_cnt_reg    <= '0;
    end else if (i_clk_en) begin
      if (!bor_en || !bor_low_s) begin
        bor_active_reg <= 1'b0;
        bor_cnt_reg    <= '0;
      end else if (!bor_active_reg) begin
        if (bor_cnt_reg == BOR_LAST) begin
          bor_active_reg <= 1'b1;
        end else begin
          bor_cnt_reg <= bor_cnt_reg + 1'b1;
        end
      end
    end
  end
  logic src_active;
  assign src_active = por_s | bor_active_reg;
  // start-up sequencer; one counter shared by all three timers
  seq_state_t       state_reg;
  seq_state_t       state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic             from_reset_reg;
  logic             pll_mode;
  assign pll_mode = (i_cfg.osc_mode == OSC_HIGH_SPEED_PLL_MODE);
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      // wait for POR pulse and brown-out reset to clear
      ST_HOLD: begin
        if (!src_active) begin
          if (!i_cfg.powerup_timer_off) begin
            state_next = ST_POWERUP_TIMER;
          end else if (needs_ost(i_cfg.osc_mode)) begin
            state_next = ST_OST;
          end else begin
            state_next = ST_RUN;
          end
        end
      end
      ST_POWERUP_TIMER: begin
        if (src_active) begin
          state_next = ST_HOLD;
        end else if (rc_tick && cnt_reg == POWERUP_TIMER_LAST) begin
          state_next = needs_ost(i_cfg.osc_mode) ? ST_OST : ST_RUN;
        end
      end
      ST_OST: begin
        if (src_active && from_reset_reg) begin
          state_next = ST_HOLD;
        end else if (osc_tick && cnt_reg == OST_LAST) begin
          state_next = pll_mode ? ST_PLL : ST_RUN;
        end
      end
      ST_PLL: begin
        if (src_active && from_reset_reg) begin
          state_next = ST_HOLD;
        end else if (cnt_reg == PLL_LAST) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (src_active) begin
          state_next = ST_HOLD;
        end else if (i_pm_exit && needs_ost(i_cfg.osc_mode)) begin
          state_next = ST_OST;
        end
      end
      default: state_next = ST_HOLD;
    endcase
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_reg <= ST_HOLD;
    end else if (i_clk_en) begin
      state_reg <= state_next;
    end
  end
  // counter restarts on every state change
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cnt_reg <= '0;
    end else if (i_clk_en) begin
      if (state_next != state_reg) begin
        cnt_reg <= '0;
      end else if ((state_reg == ST_POWERUP_TIMER && rc_tick) ||
                   (state_reg == ST_OST && osc_tick) ||
                   (state_reg == ST_PLL)) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
  // wake-up start-up waits stall the clock but are not a reset
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      from_reset_reg <= 1'b1;
    end else if (i_clk_en) begin
      if (state_reg == ST_HOLD) begin
        from_reset_reg <= 1'b1;
      end else if (state_reg == ST_RUN && state_next == ST_OST) begin
        from_reset_reg <= 1'b0;
      end
    end
  end
  // status flags; hardware clear wins over software set
  logic por_flag_n_reg;
  logic bor_flag_n_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      por_flag_n_reg <= FLAG_CLEARED;
    end else if (i_clk_en) begin
      // only POR clears, only software sets
      if (por_s) begin
        por_flag_n_reg <= FLAG_CLEARED;
      end else if (i_por_flag_wr_one) begin
        por_flag_n_reg <= FLAG_SET;
      end
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      bor_flag_n_reg <= FLAG_CLEARED;
    end else if (i_clk_en) begin
      if (por_s || (bor_en && bor_active_reg)) begin
        bor_flag_n_reg <= FLAG_CLEARED;
      end else if (i_brownout_flag_wr_one) begin
        bor_flag_n_reg <= FLAG_SET;
      end
    end
  end
  // registered outputs
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_core_reset         <= 1'b1;
      o_startup_busy       <= 1'b1;
      o_ext_pin_data       <= 1'b0;
      o_brownout_level_sel <= '0;
      o_brownout_detect_en <= 1'b0;
      o_status             <= '0;
      o_seq_state          <= ST_HOLD;
    end else if (i_clk_en) begin
      // released only when all sources and timers done
      // wake from run only stalls the clock, no reset pulse on the way in
      o_core_reset <= ext_active | src_active |
                      ((state_next != ST_RUN) & (state_reg != ST_RUN) & from_reset_reg);
      o_startup_busy <= (state_next != ST_RUN);
      o_ext_pin_data <= i_cfg.ext_reset_pin_enable ? 1'b0 : pin_s;
      o_brownout_level_sel <= i_cfg.brownout_level_sel;
      o_brownout_detect_en <= bor_en;
      o_status.sw_brownout_enable <= mode_sw & sw_bor_en_reg;
      o_status.por_flag_n         <= por_flag_n_reg;
      o_status.brownout_flag_n    <= bor_flag_n_reg;
      o_seq_state                 <= state_next;
    end
  end
  always_ff @(posedge i_core_clk) begin
    o_ext_reset_pin_out <= 1'b0;
    o_ext_reset_pin_oe  <= 1'b0;
  end
endmodule : reset_sequencer

/* board_supply_model.sv */
`timescale 1ns/100ps
module board_supply_model #(
  parameter int RC_HALF  = 3,
  parameter int OSC_HALF = 2
) (
  input  wire logic i_clk,
  input  wire logic i_pin_pull_low,
  output logic      o_pin_n,
  output logic      o_rc_clk,
  output logic      o_osc_clk
);
  int rc_cnt  = 0;
  int osc_cnt = 0;
  // pin has a pull-up: released reads high, never floats
  assign o_pin_n = !i_pin_pull_low;
  // both sources free-run; rc kept under a quarter of core rate
  always @(posedge i_clk) begin
    rc_cnt  <= (rc_cnt == 2 * RC_HALF - 1) ? 0 : rc_cnt + 1;
    osc_cnt <= (osc_cnt == 2 * OSC_HALF - 1) ? 0 : osc_cnt + 1;
  end
  assign o_rc_clk  = rc_cnt >= RC_HALF;
  assign o_osc_clk = osc_cnt >= OSC_HALF;
endmodule : board_supply_model

/* reset_sequencer_properties.sv */
`timescale 1ns/100ps
module reset_sequencer_checker
  import reset_seq_pkg::*;
(
  input wire logic                      i_core_clk,
  input wire logic                      i_reset,
  input wire reset_seq_pkg::cfg_t       i_cfg,
  input wire logic                      i_ext_reset_pin_n,
  input wire logic                      i_por_pulse,
  input wire logic                      i_brownout_below,
  input wire logic                      o_core_reset,
  input wire logic                      o_ext_reset_pin_out,
  input wire logic                      o_ext_reset_pin_oe,
  input wire logic                      o_ext_pin_data,
  input wire logic                      o_brownout_detect_en,
  input wire reset_seq_pkg::status_t    o_status,
  input wire reset_seq_pkg::seq_state_t o_seq_state
);
  logic [7:0] run_cnt;
  logic [7:0] pin_cnt;
  logic [7:0] bor_cnt;
  logic [7:0] por_age;
  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h1;
  endfunction : inc
  // saturating counters stand in for long repetitions
  always_ff @(posedge i_core_clk) begin
    run_cnt <= i_reset ? 8'h0 : inc(run_cnt);
    pin_cnt <= (i_ext_reset_pin_n || !i_cfg.ext_reset_pin_enable) ? 8'h0 : inc(pin_cnt);
    bor_cnt <= (i_brownout_below && o_brownout_detect_en) ? inc(bor_cnt) : 8'h0;
    por_age <= i_por_pulse ? 8'h0 : inc(por_age);
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);
  property p_pin_idle; !o_ext_reset_pin_oe && !o_ext_reset_pin_out; endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("reset pin driven");
  property p_pin_hold; pin_cnt >= 8'h10 |-> o_core_reset; endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin low without reset");
  property p_bor_trip; bor_cnt >= 8'h30 |-> o_core_reset; endproperty
  a_bor_trip: assert property (p_bor_trip) else $error("brown-out not reset");
  property p_por_flag; $fell(o_status.por_flag_n) |-> por_age < 8'h6; endproperty
  a_por_flag: assert property (p_por_flag) else $error("por flag cleared");
  property p_pin_data;
    run_cnt > 8'h4 |->
      o_ext_pin_data == (!i_cfg.ext_reset_pin_enable && $past(i_ext_reset_pin_n, 3));
  endproperty
  a_pin_data: assert property (p_pin_data) else $error("pin data wrong");
  property p_mode_fixed;
    run_cnt > 8'h2 && i_cfg.brownout_mode_sel[0] == i_cfg.brownout_mode_sel[1]
      |-> o_brownout_detect_en == i_cfg.brownout_mode_sel[0];
  endproperty
  a_mode_fixed: assert property (p_mode_fixed) else $error("fixed mode wrong");
  property p_sw_zero;
    run_cnt > 8'h2 && i_cfg.brownout_mode_sel != BOR_MODE_SW |-> !o_status.sw_brownout_enable;
  endproperty
  a_sw_zero: assert property (p_sw_zero) else $error("sw enable not zero");
  property p_release; $fell(o_core_reset) |-> o_seq_state == ST_RUN; endproperty
  a_release: assert property (p_release) else $error("early release");
  property p_no_powerup_timer; i_cfg.powerup_timer_off |-> o_seq_state != ST_POWERUP_TIMER; endproperty
  a_no_powerup_timer: assert property (p_no_powerup_timer) else $error("timer not bypassed");
  c_pll: cover property (o_seq_state == ST_PLL);
  c_bor: cover property (bor_cnt == 8'h30);
  c_pin: cover property (pin_cnt == 8'h10);
endmodule : reset_sequencer_checker

bind reset_sequencer reset_sequencer_checker chk_u (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_cfg(i_cfg),
  .i_ext_reset_pin_n(i_ext_reset_pin_n), .i_por_pulse(i_por_pulse),
  .i_brownout_below(i_brownout_below), .o_core_reset(o_core_reset),
  .o_ext_reset_pin_out(o_ext_reset_pin_out), .o_ext_reset_pin_oe(o_ext_reset_pin_oe),
  .o_ext_pin_data(o_ext_pin_data), .o_brownout_detect_en(o_brownout_detect_en),
  .o_status(o_status), .o_seq_state(o_seq_state)
);

/* tb.sv */
`timescale 1ns/100ps
module tb;
  import reset_seq_pkg::*;
  localparam int PLL_N  = 50;
  localparam int RC_H   = 3;
  localparam int OSC_H  = 2;
  localparam int POWERUP_TIMER_N = 2 * RC_H * POWERUP_TIMER_TICKS;
  localparam int OST_N  = 2 * OSC_H * OST_CYCLES;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  cfg_t        cfg = '{1'b1, BOR_MODE_ON, 2'h1, 1'b0, OSC_HS};
  logic        pin_low = 1'b0, por = 1'b1, below = 1'b0, sleep = 1'b0, pm_exit = 1'b0;
  logic        sw_wr = 1'b0, sw_d = 1'b0, por_set = 1'b0, bor_set = 1'b0;
  logic        pin_n, rc, osc, core_rst, busy, pin_data, det, saw, keep, exp_det;
  logic [1:0]  lvl;
  status_t     st;
  seq_state_t  state;
  logic [15:0] lfsr = 16'h72fd;
  int          failures = 0;
  int          cmp_count = 0;

  always #2.5 clk = ~clk;

  board_supply_model #(.RC_HALF(RC_H), .OSC_HALF(OSC_H)) board_u (
    .i_clk(clk), .i_pin_pull_low(pin_low), .o_pin_n(pin_n), .o_rc_clk(rc), .o_osc_clk(osc));

  reset_sequencer #(.PLL_LOCK_CYCLES(PLL_N)) dut_u (
    .i_core_clk(clk), .i_reset(rst), .i_clk_en(1'b1), .i_cfg(cfg),
    .i_ext_reset_pin_n(pin_n), .i_por_pulse(por), .i_brownout_below(below),
    .i_internal_rc_clock(rc), .i_osc_input_pin(osc), .i_sleep(sleep), .i_pm_exit(pm_exit),
    .i_sw_brownout_wr(sw_wr), .i_sw_brownout_wdata(sw_d), .i_por_flag_wr_one(por_set),
    .i_brownout_flag_wr_one(bor_set), .o_core_reset(core_rst), .o_startup_busy(busy),
    .o_ext_reset_pin_out(), .o_ext_reset_pin_oe(), .o_ext_pin_data(pin_data),
    .o_brownout_level_sel(lvl), .o_brownout_detect_en(det), .o_status(st),
    .o_seq_state(state));

  function automatic logic [15:0] next_rand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : next_rand

  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : chk

  task automatic chk_len(input int got, input int exp, input string m);
    cmp_count++;
    if (got < exp - 8 || got > exp + 8) begin
      failures++;
      $display("mismatch %0t %s %0d vs %0d", $time, m, got, exp);
    end
  endtask : chk_len

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic watch(input int n);
    saw = 1'b0;
    repeat (n) begin
      @(posedge clk);
      if (core_rst !== 1'b0) saw = 1'b1;
    end
  endtask : watch

  task automatic wait_st(input seq_state_t s, input int lim);
    int n;
    n = 0;
    while (state !== s && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (state !== s) begin
      chk(4'h1, 4'h0, "state wait timed out");
      give_verdict();
    end
  endtask : wait_st

  task automatic rel(input int lim, input int exp);
    int n;
    n = 0;
    while (core_rst !== 1'b0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk_len(n, exp, "release delay");
    if (core_rst !== 1'b0) give_verdict();
  endtask : rel

  task automatic span(input seq_state_t s, input int exp, input string m);
    int n;
    n = 0;
    saw = 1'b0;
    while (state === s && n < 2 * exp + 50) begin
      @(posedge clk);
      n++;
      if (core_rst !== 1'b0) saw = 1'b1;
    end
    chk_len(n, exp, m);
  endtask : span

  // pulse first so the flag drops outside i_reset, then reload config
  task automatic power_up(input cfg_t c);
    por <= 1'b1;
    cyc(5);
    chk(st.por_flag_n, FLAG_CLEARED, "por flag");
    rst <= 1'b1;
    cfg <= c;
    cyc(1);
    rst <= 1'b0;
    cyc(3);
    chk(state, ST_HOLD, "hold while por");
    por <= 1'b0;
  endtask : power_up

  task automatic set_flags();
    por_set <= 1'b1;
    bor_set <= 1'b1;
    cyc(1);
    por_set <= 1'b0;
    bor_set <= 1'b0;
    cyc(3);
  endtask : set_flags

  initial begin
    power_up(cfg);
    wait_st(ST_POWERUP_TIMER, 8);
    span(ST_POWERUP_TIMER, POWERUP_TIMER_N, "powerup_timer length");
    chk(state, ST_OST, "ost follows");
    span(ST_OST, OST_N, "ost length");
    cyc(2);
    chk(core_rst, 1'b0, "released");
    set_flags();
    chk(st, 4'h3, "flags set");
    lfsr = next_rand(lfsr);
    pin_low <= 1'b1;
    cyc(1 + lfsr[2:0] % 7);
    pin_low <= 1'b0;
    watch(20);
    chk(saw, 1'b0, "glitch");
    pin_low <= 1'b1;
    watch(30);
    chk(core_rst, 1'b1, "pin reset");
    chk(st, 4'h3, "flags kept");
    pin_low <= 1'b0;
    rel(40, 4 + EXT_FILTER_CYCLES);
    pm_exit <= 1'b1;
    cyc(1);
    pm_exit <= 1'b0;
    wait_st(ST_OST, 8);
    chk(busy, 1'b1, "wake busy");
    chk(core_rst, 1'b0, "wake no pulse");
    span(ST_OST, OST_N, "wake ost");
    chk(saw, 1'b0, "wake no reset");
    power_up('{1'b1, BOR_MODE_ON, 2'h2, 1'b1, OSC_HIGH_SPEED_PLL_MODE});
    wait_st(ST_OST, 8);
    span(ST_OST, OST_N, "pll ost");
    chk(state, ST_PLL, "pll follows");
    span(ST_PLL, PLL_N, "pll length");
    power_up('{1'b0, BOR_MODE_OFF, 2'h3, 1'b1, OSC_RC});
    rel(20, 3);
    pin_low <= 1'b1;
    watch(30);
    chk(saw, 1'b0, "disabled pin");
    chk(pin_data, 1'b0, "pin as input");
    pin_low <= 1'b0;
    cyc(5);
    chk(pin_data, 1'b1, "pin high as input");
    for (int m = 0; m < 4; m++) begin
      lfsr = next_rand(lfsr);
      power_up('{1'b1, m[1:0], lfsr[1:0], 1'b1, OSC_RC});
      rel(20, 3);
      chk(lvl, lfsr[1:0], "level copy");
      chk(st.sw_brownout_enable, m == 1, "sw bit");
      keep = lfsr[4];
      if (m == 1 || m == 3) begin
        sw_wr <= 1'b1;
        sw_d <= keep;
        cyc(1);
        sw_wr <= 1'b0;
      end
      if (m == 2) sleep <= !keep;
      exp_det = (m == 3) || (m != 0 && keep);
      set_flags();
      chk(det, exp_det, "detect enable");
      below <= 1'b1;
      cyc(20);
      below <= 1'b0;
      watch(10);
      chk(saw, 1'b0, "short dip");
      below <= 1'b1;
      watch(100);
      chk(core_rst, exp_det, "long dip");
      chk(st.brownout_flag_n, !exp_det, "bor flag");
      chk(st.por_flag_n, FLAG_SET, "por flag kept");
      below <= 1'b0;
      sleep <= 1'b0;
      rel(20, 4);
    end
    power_up('{1'b1, BOR_MODE_ON, 2'h0, 1'b0, OSC_RC});
    wait_st(ST_POWERUP_TIMER, 8);
    cyc(1000);
    below <= 1'b1;
    wait_st(ST_HOLD, 60);
    chk(core_rst, 1'b1, "bor in powerup_timer");
    cyc(20);
    below <= 1'b0;
    wait_st(ST_POWERUP_TIMER, 20);
    span(ST_POWERUP_TIMER, POWERUP_TIMER_N, "powerup_timer restarted");
    chk(state, ST_RUN, "no ost in rc");
    give_verdict();
  end
endmodule : tb
